// [bench/dma_core_props.sv]
// concurrent checks on the ports of the data memory addressing core
`timescale 1ns/1ps
module dma_core_props
	import dma_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	input wire dma_req_t req_i,
	input wire logic busy_o,
	input wire dma_rsp_t rsp_o,
	input wire logic [7:0] stack_pointer_o,
	input wire logic [1:0] bank_sel_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);
	logic tk;
	assign tk = req_valid_i && !busy_o;
	property p_sp_rst;
		$fell(sys_rst_i) |-> stack_pointer_o == SP_RESET;
	endproperty
	a_sp_rst: assert property (p_sp_rst) else $error("stack pointer not 07 after reset");
	property p_push;
		tk && req_i.op == OP_PUSH |->
			##3 rsp_o.done && stack_pointer_o == $past(stack_pointer_o, 3) + 8'h01;
	endproperty
	a_push: assert property (p_push) else $error("push result wrong");
	// a pop moves the pointer on its read step, so the trailing copy shows it after done
	property p_pop;
		tk && req_i.op == OP_POP |->
			##3 rsp_o.done ##1 stack_pointer_o == $past(stack_pointer_o, 4) - 8'h01;
	endproperty
	a_pop: assert property (p_pop) else $error("pop result wrong");
	property p_call;
		tk && req_i.op == OP_CALL_SAVE |->
			##4 rsp_o.done && stack_pointer_o == $past(stack_pointer_o, 4) + 8'h02;
	endproperty
	a_call: assert property (p_call) else $error("call save result wrong");
	property p_interrupt_return_op;
		tk && req_i.op == OP_INTERRUPT_RETURN |->
			##4 rsp_o.done ##1 stack_pointer_o == $past(stack_pointer_o, 5) - 8'h02;
	endproperty
	a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("return result wrong");
	property p_rmw;
		tk && req_i.op inside {OP_INDIRECT_INCREMENT, OP_REGISTER_DECREMENT, OP_BIT_CLEAR}
			|=> busy_o [*3] ##1 rsp_o.done;
	endproperty
	a_rmw: assert property (p_rmw) else $error("read modify write timing wrong");
	property p_unimpl;
		tk && req_i.op == OP_READ_DIRECT && req_i.addr == 8'h84 |-> ##3 rsp_o.rdata == UNIMPL_READ;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("empty address not FF");
	property p_bank;
		tk && req_i.op == OP_WRITE_DIRECT && req_i.addr == PROGRAM_STATUS_WORD_ADDR |->
			##5 bank_sel_o == $past(req_i.wdata[4:3], 5);
	endproperty
	a_bank: assert property (p_bank) else $error("bank select not taken");
endmodule : dma_core_props

// [bench/dma_cpu_model.sv]
// sequencer model that issues one access at a time and waits for it
`timescale 1ns/1ps
module dma_cpu_model
	import dma_pkg::*;
(
	input wire logic mclk_i,
	input wire dma_rsp_t rsp_i,
	output logic req_valid_o,
	output dma_req_t req_o
);
	dma_rsp_t got;
	initial begin
		req_valid_o = 1'b0;
		req_o = '0;
	end
	task automatic issue(input dma_op_t op, input logic [2:0] rs, input logic [7:0] a,
		input logic [7:0] w, input logic [15:0] pc);
		@(posedge mclk_i);
		#1;
		req_valid_o = 1'b1;
		req_o = '{op, rs, a, w, pc};
		@(posedge mclk_i);
		#1;
		req_valid_o = 1'b0;
		// released lines flip so a stale value is never mistaken for a live one
		req_o = ~req_o;
		for (int i = 0; i < 8 && rsp_i.done !== 1'b1; i++) begin
			@(posedge mclk_i);
			#1;
		end
		got = rsp_i;
	endtask : issue
endmodule : dma_cpu_model

// [bench/test_data_memory_addressing.sv]
// self-checking bench with a reference model of the data memory
`timescale 1ns/1ps
module test_data_memory_addressing
	import dma_pkg::*;
;
	logic mclk_i = 1'b0;
	logic sys_rst_i;
	logic req_valid_i;
	dma_req_t req_i;
	logic busy_o;
	dma_rsp_t rsp_o;
	logic [7:0] stack_pointer_o;
	logic [1:0] bank_sel_o;
	int failures = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'h0103CDE5;
	logic [7:0] ram [256];
	logic [7:0] sfr [256];
	bit imp [256];
	logic [7:0] sp = SP_RESET;
	logic [7:0] ad;
	dma_op_t bops [5] = '{OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_COMPLEMENT, OP_BIT_TEST, OP_BIT_WRITE};

	always #50 mclk_i = ~mclk_i;

	dma_core i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .busy_o(busy_o), .rsp_o(rsp_o), .stack_pointer_o(stack_pointer_o),
		.bank_sel_o(bank_sel_o));
	dma_cpu_model i_cpu (.mclk_i(mclk_i), .rsp_i(rsp_o), .req_valid_o(req_valid_i),
		.req_o(req_i));

	function automatic logic [31:0] nx();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : nx

	function automatic logic [7:0] rd(input logic [7:0] a);
		if (a < SFR_SPACE_BASE) return ram[a];
		if (a == STACK_POINTER_ADDR) return sp;
		return imp[a] ? sfr[a] : UNIMPL_READ;
	endfunction : rd

	task automatic wd(input logic [7:0] a, input logic [7:0] v);
		if (a < SFR_SPACE_BASE) ram[a] = v;
		else if (a == STACK_POINTER_ADDR) sp = v;
		else if (imp[a]) sfr[a] = v;
	endtask : wd

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t byte got %h exp %h", $time, got, exp);
		end
	endtask : cmp_byte

	task automatic cmp_pc(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t pc got %h exp %h", $time, got, exp);
		end
	endtask : cmp_pc

	// model first, then the real access, then stack pointer, done and the op's read, bit or pc result compared
	task automatic go(input dma_op_t o, input logic [7:0] a = 8'h00, input logic [2:0] rs = 3'h0,
		input logic [7:0] w = 8'h00, input logic [15:0] pc = 16'h0000);
		logic [7:0] ra, ia, ba, v, e;
		logic [15:0] ep;
		int k;
		ra = {3'h0, sfr[PROGRAM_STATUS_WORD_ADDR][4:3], rs};
		ia = ram[{3'h0, sfr[PROGRAM_STATUS_WORD_ADDR][4:3], 2'h0, rs[0]}];
		ba = a[7] ? {a[7:3], 3'h0} : BIT_RAM_BASE + 8'(a[6:3]);
		v = rd(ba);
		e = 8'h00;
		ep = 16'h0000;
		k = (o inside {OP_READ_DIRECT, OP_READ_INDIRECT, OP_READ_REG, OP_POP,
			OP_INDIRECT_INCREMENT}) ? 1 : 0;
		case (o)
			OP_READ_DIRECT: e = rd(a);
			OP_WRITE_DIRECT: wd(a, w);
			OP_READ_INDIRECT: e = ram[ia];
			OP_WRITE_INDIRECT: ram[ia] = w;
			OP_READ_REG: e = ram[ra];
			OP_WRITE_REG: ram[ra] = w;
			OP_REGISTER_DECREMENT: ram[ra]--;
			OP_PUSH: begin
				sp++;
				ram[sp] = w;
			end
			OP_POP: begin
				e = ram[sp];
				sp--;
			end
			OP_CALL_SAVE: begin
				ram[sp + 8'h01] = pc[7:0];
				ram[sp + 8'h02] = pc[15:8];
				sp += 8'h02;
			end
			OP_INTERRUPT_RETURN: begin
				ep = {ram[sp], ram[sp - 8'h01]};
				sp -= 8'h02;
				k = 3;
			end
			OP_INDIRECT_INCREMENT: begin
				ram[ia]++;
				e = ram[ia];
			end
			OP_BIT_TEST: begin
				e = {7'h00, v[a[2:0]]};
				k = 2;
			end
			default: begin
				v[a[2:0]] = (o == OP_BIT_SET) || (o == OP_BIT_WRITE && w[0]) ||
					(o == OP_BIT_COMPLEMENT && !v[a[2:0]]);
				wd(ba, v);
			end
		endcase
		i_cpu.issue(o, rs, a, w, pc);
		@(posedge mclk_i);
		#1;
		cmp_byte(stack_pointer_o, sp);
		cmp_byte({7'h00, i_cpu.got.done}, 8'h01);
		if (k == 1) cmp_byte(i_cpu.got.rdata, e);
		if (k == 2) cmp_byte({7'h00, i_cpu.got.bit_value}, e);
		if (k == 3) cmp_pc(i_cpu.got.pc, ep);
	endtask : go

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	initial begin
		foreach (SFR_TABLE[i]) begin
			imp[SFR_TABLE[i]] = 1'b1;
			sfr[SFR_TABLE[i]] = SFR_RESET;
		end
		sys_rst_i = 1'b1;
		repeat (16) @(posedge mclk_i);
		#1;
		sys_rst_i = 1'b0;
		cmp_byte(stack_pointer_o, SP_RESET);
		foreach (SFR_TABLE[i]) begin
			ad = SFR_TABLE[i];
			go(OP_READ_DIRECT, ad);
			go(OP_WRITE_DIRECT, ad, 3'h0, 8'(nx()));
			go(OP_READ_DIRECT, ad);
			if (ad[2:0] == 3'h0) begin
				go(bops[i % 5], {ad[7:3], 3'(nx())}, 3'h0, 8'(nx()));
				go(OP_READ_DIRECT, ad);
			end
		end
		go(OP_WRITE_DIRECT, 8'h84, 3'h0, 8'(nx()));
		go(OP_READ_DIRECT, 8'h84);
		go(OP_BIT_SET, 8'hC5);
		go(OP_BIT_TEST, 8'hC5);
		$display("special register tests done");
		for (int b = 0; b < 4; b++) begin
			go(OP_WRITE_DIRECT, PROGRAM_STATUS_WORD_ADDR, 3'h0, {3'(nx()), 2'(b), 3'(nx())});
			for (int r = 0; r < 8; r++) begin
				go(OP_WRITE_REG, 8'h00, 3'(r), 8'(nx()));
				go(OP_REGISTER_DECREMENT, 8'h00, 3'(r));
				go(OP_READ_REG, 8'h00, 3'(r));
				go(OP_READ_DIRECT, 8'(8 * b + r));
			end
		end
		$display("bank tests done");
		for (int r = 0; r < 4; r++) begin
			ad = 8'h80 | 8'(nx());
			go(OP_WRITE_REG, 8'h00, 3'(r % 2), ad);
			go(OP_WRITE_INDIRECT, 8'h00, {2'(nx()), 1'(r)}, 8'(nx()));
			go(OP_INDIRECT_INCREMENT, 8'h00, {2'(nx()), 1'(r)});
			go(OP_READ_INDIRECT, 8'h00, {2'(nx()), 1'(r)});
			go(OP_READ_DIRECT, ad);
		end
		for (int i = 0; i < 20; i++) begin
			ad = 8'(nx()) & 8'h7F;
			go(OP_WRITE_DIRECT, BIT_RAM_BASE + 8'(ad[6:3]), 3'h0, 8'(nx()));
			go(bops[i % 5], ad, 3'h0, 8'(nx()));
			go(OP_READ_DIRECT, BIT_RAM_BASE + 8'(ad[6:3]));
		end
		$display("indirect and bit tests done");
		go(OP_WRITE_DIRECT, STACK_POINTER_ADDR, 3'h0, 8'h7F);
		go(OP_CALL_SAVE, 8'h00, 3'h0, 8'h00, 16'(nx()));
		go(OP_PUSH, 8'h00, 3'h0, 8'(nx()));
		go(OP_READ_DIRECT, STACK_POINTER_ADDR);
		go(OP_POP);
		go(OP_WRITE_REG, 8'h00, 3'h1, 8'h80);
		go(OP_READ_INDIRECT, 8'h00, 3'h1);
		go(OP_INTERRUPT_RETURN);
		go(OP_WRITE_DIRECT, STACK_POINTER_ADDR, 3'h0, 8'hFF);
		go(OP_PUSH, 8'h00, 3'h0, 8'(nx()));
		go(OP_POP);
		go(OP_CALL_SAVE, 8'h00, 3'h0, 8'h00, 16'(nx()));
		go(OP_INTERRUPT_RETURN);
		$display("stack tests done");
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge mclk_i);
		failures++;
		print_verdict();
	end
endmodule : test_data_memory_addressing

bind dma_core dma_core_props i_props (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
	.req_valid_i(req_valid_i), .req_i(req_i), .busy_o(busy_o), .rsp_o(rsp_o),
	.stack_pointer_o(stack_pointer_o), .bank_sel_o(bank_sel_o));

// [hw/dma_core.sv]
// data memory addressing: stack, banked registers, indirect and bit access
//
// Summary of operation
// RL1: reset loads stack pointer with 07H, writable
// RL2: call uses two stack bytes, push one
// RL3: save increments then writes low, then high
// RL4: pop reads then decrements; return pops high first
// RL5: opcode bit 0 picks pointer register zero/one
// RL6: indirect increment latches pointer, reads, adds, writes
// RL7: opcode bits 2..0 pick working register
// RL8: register decrement reads, subtracts one, writes back
// RL9: bit ops work on RAM bytes 20H-2FH
// RL10: bit number is low three bits, weights 1,2,4
// RL11: RAM bit byte is 20H plus bits 6..3
// RL12: bit clear reads byte, clears bit, writes back
// RL13: twenty-seven byte-addressable special function registers
// RL14: thirteen bit-addressable registers, address plus bit
// RL15: empty special address reads 0FFH, writes ignored
// RL16: software avoids empty special function addresses
// RL17: bank select bits pick 8n..8n+7 bank
// RL18: direct upper half hits registers, indirect hits RAM
// RL19: bit address low three bits pick bit
// RL20: stack pointer wraps modulo 256
`timescale 1ns/1ps
module dma_core
	import dma_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	input wire dma_req_t req_i,
	output logic busy_o,
	output dma_rsp_t rsp_o,
	output logic [7:0] stack_pointer_o,
	output logic [1:0] bank_sel_o
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_LATCH = 5'b00010,
		ST_READ = 5'b00100,
		ST_WRITE = 5'b01000,
		ST_SECOND = 5'b10000
	} dma_state_t;

	dma_state_t state;
	dma_state_t next_state;
	dma_req_t cur;
	logic [7:0] stack_pointer;
	logic [7:0] addr_latch;
	logic to_sfr;
	logic [7:0] temp;
	logic [7:0] program_status_word;
	logic [1:0] bank;
	logic [7:0] ptr_addr;
	logic [7:0] ptr_value;
	logic [7:0] ram_rdata;
	logic [7:0] sfr_rdata;
	logic [7:0] read_now;
	logic [7:0] bit_mask;
	logic [7:0] modified;
	logic ram_we;
	logic sfr_we;
	logic [7:0] wr_data;
	logic take;
	logic is_bit_op;
	logic is_simple_write;
	logic is_rmw;
	logic sp_hit;
	logic [7:0] bit_byte;
	logic bit_in_sfr;

	assign take = req_valid_i && !busy_o;
	assign bank = {program_status_word[PSW_BANK_HIGH_POS], program_status_word[PSW_BANK_LOW_POS]}; // see RL17

	// pointer register zero or one inside the current bank
	assign ptr_addr = {3'h0, bank, 2'h0, cur.reg_sel[0]}; // see RL5

	assign is_bit_op = (cur.op == OP_BIT_CLEAR) || (cur.op == OP_BIT_SET) ||
		(cur.op == OP_BIT_COMPLEMENT) || (cur.op == OP_BIT_TEST) ||
		(cur.op == OP_BIT_WRITE);
	assign is_simple_write = (cur.op == OP_WRITE_DIRECT) ||
		(cur.op == OP_WRITE_INDIRECT) || (cur.op == OP_WRITE_REG) ||
		(cur.op == OP_PUSH);

	// read-modify-write ops need one more step to put the result back
	assign is_rmw = (cur.op == OP_INDIRECT_INCREMENT) ||
		(cur.op == OP_REGISTER_DECREMENT) || (is_bit_op && cur.op != OP_BIT_TEST);
	// the stack pointer sits outside the register file, so its hits are caught here
	assign sp_hit = to_sfr && (addr_latch == STACK_POINTER_ADDR);

	// bit 7 picks the space: a special register base or one of sixteen ram bytes
	always_comb begin
		if (cur.addr[BIT_SPACE_POS]) begin
			bit_byte = {cur.addr[7:3], 3'h0}; // see RL14 see RL19
			bit_in_sfr = 1'b1;
		end else begin
			bit_byte = BIT_RAM_BASE + {4'h0, cur.addr[6:3]}; // see RL11
			bit_in_sfr = 1'b0;
		end
	end

	dma_ram u_ram (
		.mclk_i(mclk_i),
		.we_i(ram_we),
		.waddr_i(addr_latch),
		.wdata_i(wr_data),
		.raddr_a_i(addr_latch),
		.rdata_a_o(ram_rdata),
		.raddr_b_i(ptr_addr),
		.rdata_b_o(ptr_value)
	);

	dma_sfr u_sfr (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.we_i(sfr_we),
		.waddr_i(addr_latch),
		.wdata_i(wr_data),
		.raddr_i(addr_latch),
		.rdata_o(sfr_rdata),
		.program_status_word_o(program_status_word)
	);

	// stack pointer is not in the register file, so its read is merged here
	always_comb begin
		if (!to_sfr) begin
			read_now = ram_rdata;
		end else if (addr_latch == STACK_POINTER_ADDR) begin
			read_now = stack_pointer;
		end else begin
			read_now = sfr_rdata;
		end
	end

	// bit number from the low three address bits, binary weighted
	assign bit_mask = 8'h01 << cur.addr[2:0]; // see RL10 see RL19

	always_comb begin
		case (cur.op)
			OP_INDIRECT_INCREMENT: modified = temp + 8'h01; // see RL6
			OP_REGISTER_DECREMENT: modified = temp - 8'h01; // see RL8
			OP_BIT_CLEAR: modified = temp & ~bit_mask; // see RL12
			OP_BIT_SET: modified = temp | bit_mask; // see RL9
			OP_BIT_COMPLEMENT: modified = temp ^ bit_mask; // see RL9
			OP_BIT_WRITE: modified = cur.wdata[0] ? (temp | bit_mask) : (temp & ~bit_mask);
			default: modified = temp;
		endcase
	end

	// write strobes come from the state, the operation and the target space, and a write lands on the latched address
	always_comb begin
		ram_we = 1'b0;
		sfr_we = 1'b0;
		wr_data = modified;
		case (state)
			ST_READ: begin
				if (cur.op == OP_CALL_SAVE) begin
					wr_data = cur.pc[7:0]; // see RL3
					ram_we = 1'b1;
				end else if (is_simple_write) begin
					wr_data = cur.wdata;
					ram_we = !to_sfr;
					sfr_we = to_sfr && !sp_hit;
				end
			end
			ST_WRITE: begin
				ram_we = !to_sfr;
				sfr_we = to_sfr && !sp_hit;
			end
			ST_SECOND: begin
				if (cur.op == OP_CALL_SAVE) begin
					wr_data = cur.pc[15:8]; // see RL3
					ram_we = 1'b1;
				end
			end
			default: begin
				wr_data = modified;
			end
		endcase
	end

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (take) begin
					next_state = ST_LATCH;
				end
			end
			ST_LATCH: begin
				next_state = ST_READ;
			end
			ST_READ: begin
				if (cur.op == OP_CALL_SAVE || cur.op == OP_INTERRUPT_RETURN) begin
					next_state = ST_SECOND; // see RL2
				end else if (is_rmw) begin
					next_state = ST_WRITE;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_WRITE: begin
				next_state = ST_IDLE;
			end
			ST_SECOND: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cur <= '0;
		end else if (take) begin
			cur <= req_i;
		end
	end

	// address latch and target space for every kind of access
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			addr_latch <= 8'h00;
			to_sfr <= 1'b0;
		end else if (state == ST_LATCH) begin
			to_sfr <= 1'b0;
			case (cur.op)
				OP_READ_DIRECT, OP_WRITE_DIRECT: begin
					addr_latch <= cur.addr;
					to_sfr <= cur.addr >= SFR_SPACE_BASE; // see RL18
				end
				OP_READ_INDIRECT, OP_WRITE_INDIRECT, OP_INDIRECT_INCREMENT: begin
					// indirect always lands in ram, upper half included
					addr_latch <= ptr_value; // see RL6 see RL18
				end
				OP_READ_REG, OP_WRITE_REG, OP_REGISTER_DECREMENT: begin
					addr_latch <= {3'h0, bank, cur.reg_sel}; // see RL7 see RL17
				end
				OP_PUSH, OP_CALL_SAVE: begin
					addr_latch <= stack_pointer + 8'h01; // see RL3 see RL20
				end
				OP_POP, OP_INTERRUPT_RETURN: begin
					addr_latch <= stack_pointer; // see RL4
				end
				OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_COMPLEMENT, OP_BIT_TEST, OP_BIT_WRITE: begin
					// 81H is not bit addressable, so no bit op lands on the stack pointer
					addr_latch <= bit_byte; // see RL9
					to_sfr <= bit_in_sfr; // see RL14
				end
				default: begin
					addr_latch <= cur.addr;
				end
			endcase
		end else if (state == ST_READ) begin
			if (cur.op == OP_CALL_SAVE) begin
				// the two pc bytes sit on neighbouring addresses, low one first
				addr_latch <= addr_latch + 8'h01; // see RL3
			end else if (cur.op == OP_INTERRUPT_RETURN) begin
				addr_latch <= addr_latch - 8'h01; // see RL4
			end
		end
	end

	// one-step moves with natural 8-bit wrap; a direct write to the pointer wins
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			stack_pointer <= SP_RESET; // see RL1
		end else if (state == ST_LATCH && (cur.op == OP_PUSH || cur.op == OP_CALL_SAVE)) begin
			stack_pointer <= stack_pointer + 8'h01; // see RL2 see RL20
		end else if (state == ST_READ) begin
			if (cur.op == OP_WRITE_DIRECT && sp_hit) begin
				stack_pointer <= cur.wdata; // see RL1
			end else if (cur.op == OP_CALL_SAVE) begin
				stack_pointer <= stack_pointer + 8'h01; // see RL2
			end else if (cur.op == OP_POP || cur.op == OP_INTERRUPT_RETURN) begin
				stack_pointer <= stack_pointer - 8'h01; // see RL4 see RL20
			end
		end else if (state == ST_SECOND && cur.op == OP_INTERRUPT_RETURN) begin
			stack_pointer <= stack_pointer - 8'h01; // see RL4
		end else if (state == ST_WRITE && sp_hit) begin
			stack_pointer <= modified;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			temp <= 8'h00;
		end else if (state == ST_READ) begin
			temp <= read_now; // see RL6 see RL8 see RL12
		end
	end

	// busy falls on the edge that raises done, so a new request may follow at once
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			busy_o <= 1'b0;
		end else if (take) begin
			busy_o <= 1'b1;
		end else if (state != ST_IDLE && next_state == ST_IDLE) begin
			busy_o <= 1'b0;
		end
	end

	// answer stands for one cycle after the last step of an operation
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rsp_o <= '0;
		end else begin
			rsp_o.done <= (state != ST_IDLE) && (next_state == ST_IDLE);
			if (state == ST_READ) begin
				rsp_o.rdata <= read_now;
				// an empty register reads all ones, so a bit test there is always set
				rsp_o.bit_value <= |(read_now & bit_mask); // see RL15
				if (cur.op == OP_INTERRUPT_RETURN) begin
					rsp_o.pc[15:8] <= read_now; // see RL4
				end
			end else if (state == ST_WRITE) begin
				rsp_o.rdata <= modified;
			end else if (state == ST_SECOND && cur.op == OP_INTERRUPT_RETURN) begin
				rsp_o.pc[7:0] <= ram_rdata; // see RL4
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			stack_pointer_o <= SP_RESET;
			bank_sel_o <= 2'h0;
		end else begin
			stack_pointer_o <= stack_pointer;
			bank_sel_o <= bank;
		end
	end
endmodule : dma_core

// [hw/dma_ram.sv]
// internal data memory: 256 bytes of flip-flops, one write and two read ports
`timescale 1ns/1ps
module dma_ram
	import dma_pkg::*;
#(
	parameter int DEPTH = RAM_DEPTH
) (
	input wire logic mclk_i,
	input wire logic we_i,
	input wire logic [7:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] raddr_a_i,
	output logic [7:0] rdata_a_o,
	input wire logic [7:0] raddr_b_i,
	output logic [7:0] rdata_b_o
);
	logic [7:0] mem [DEPTH];

	// contents are undefined after reset, like any static ram
	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	assign rdata_a_o = mem[raddr_a_i];
	assign rdata_b_o = mem[raddr_b_i];
endmodule : dma_ram

// [hw/dma_sfr.sv]
// special function register file with all-ones answer for empty addresses
`timescale 1ns/1ps
module dma_sfr
	import dma_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic we_i,
	input wire logic [7:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] raddr_i,
	output logic [7:0] rdata_o,
	output logic [7:0] program_status_word_o
);
	logic [7:0] regs [SFR_COUNT];
	logic [SFR_COUNT-1:0] hit;

	genvar gi;
	generate
		for (gi = 0; gi < SFR_COUNT; gi++) begin : g_reg
			assign hit[gi] = (raddr_i == SFR_TABLE[gi]);
			// a write to an empty address matches no entry and changes nothing; see RL15
			always_ff @(posedge mclk_i) begin
				if (sys_rst_i) begin
					regs[gi] <= SFR_RESET;
				end else if (we_i && waddr_i == SFR_TABLE[gi]) begin
					regs[gi] <= wdata_i;
				end
			end
		end
	endgenerate

	always_comb begin
		rdata_o = UNIMPL_READ; // see RL15
		for (int i = 0; i < SFR_COUNT; i++) begin
			if (hit[i]) begin
				rdata_o = regs[i]; // see RL13
			end
		end
	end

	always_comb begin
		program_status_word_o = SFR_RESET;
		for (int i = 0; i < SFR_COUNT; i++) begin
			if (SFR_TABLE[i] == PROGRAM_STATUS_WORD_ADDR) begin
				program_status_word_o = regs[i];
			end
		end
	end
endmodule : dma_sfr

// [shared/dma_pkg.sv]
// shared constants and types for the data memory addressing block
package dma_pkg;
	localparam int RAM_DEPTH = 256;
	localparam int SFR_COUNT = 26;
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] SFR_RESET = 8'h00;
	localparam logic [7:0] UNIMPL_READ = 8'hFF;
	localparam logic [7:0] SFR_SPACE_BASE = 8'h80;
	localparam logic [7:0] BIT_RAM_BASE = 8'h20;
	localparam int BIT_SPACE_POS = 7;
	localparam int PSW_BANK_HIGH_POS = 4;
	localparam int PSW_BANK_LOW_POS = 3;
	localparam logic [7:0] PORT0_LATCH_ADDR = 8'h80;
	localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
	localparam logic [7:0] DATA_POINTER_LOW_ADDR = 8'h82;
	localparam logic [7:0] DATA_POINTER_HIGH_ADDR = 8'h83;
	localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
	localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h88;
	localparam logic [7:0] TIMER_MODE_SELECT_ADDR = 8'h89;
	localparam logic [7:0] TIMER0_COUNT_LOW_ADDR = 8'h8A;
	localparam logic [7:0] TIMER1_COUNT_LOW_ADDR = 8'h8B;
	localparam logic [7:0] TIMER0_COUNT_HIGH_ADDR = 8'h8C;
	localparam logic [7:0] TIMER1_COUNT_HIGH_ADDR = 8'h8D;
	localparam logic [7:0] PORT1_LATCH_ADDR = 8'h90;
	localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'h98;
	localparam logic [7:0] SERIAL_BUFFER_ADDR = 8'h99;
	localparam logic [7:0] PORT2_LATCH_ADDR = 8'hA0;
	localparam logic [7:0] INTERRUPT_ENABLE_ADDR = 8'hA8;
	localparam logic [7:0] PORT3_LATCH_ADDR = 8'hB0;
	localparam logic [7:0] INTERRUPT_PRIORITY_ADDR = 8'hB8;
	localparam logic [7:0] TIMER2_CONTROL_ADDR = 8'hC8;
	localparam logic [7:0] TIMER2_CAPTURE_LOW_ADDR = 8'hCA;
	localparam logic [7:0] TIMER2_CAPTURE_HIGH_ADDR = 8'hCB;
	localparam logic [7:0] TIMER2_COUNT_LOW_ADDR = 8'hCC;
	localparam logic [7:0] TIMER2_COUNT_HIGH_ADDR = 8'hCD;
	localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hD0;
	localparam logic [7:0] MAIN_OPERAND_ADDR = 8'hE0;
	localparam logic [7:0] MULTIPLY_OPERAND_ADDR = 8'hF0;
	localparam logic [7:0] IO_CONFIG_ADDR = 8'hF8;
	// stack pointer lives in the top module, so it is not in this table
	localparam logic [7:0] SFR_TABLE [SFR_COUNT] = '{
		PORT0_LATCH_ADDR, DATA_POINTER_LOW_ADDR, DATA_POINTER_HIGH_ADDR,
		POWER_CONTROL_ADDR, TIMER_CONTROL_ADDR, TIMER_MODE_SELECT_ADDR,
		TIMER0_COUNT_LOW_ADDR, TIMER1_COUNT_LOW_ADDR, TIMER0_COUNT_HIGH_ADDR,
		TIMER1_COUNT_HIGH_ADDR, PORT1_LATCH_ADDR, SERIAL_CONTROL_ADDR,
		SERIAL_BUFFER_ADDR, PORT2_LATCH_ADDR, INTERRUPT_ENABLE_ADDR,
		PORT3_LATCH_ADDR, INTERRUPT_PRIORITY_ADDR, TIMER2_CONTROL_ADDR,
		TIMER2_CAPTURE_LOW_ADDR, TIMER2_CAPTURE_HIGH_ADDR, TIMER2_COUNT_LOW_ADDR,
		TIMER2_COUNT_HIGH_ADDR, PROGRAM_STATUS_WORD_ADDR, MAIN_OPERAND_ADDR,
		MULTIPLY_OPERAND_ADDR, IO_CONFIG_ADDR
	};

	typedef enum logic [4:0] {
		OP_NONE = 5'h00,
		OP_READ_DIRECT = 5'h01,
		OP_WRITE_DIRECT = 5'h02,
		OP_READ_INDIRECT = 5'h03,
		OP_WRITE_INDIRECT = 5'h04,
		OP_READ_REG = 5'h05,
		OP_WRITE_REG = 5'h06,
		OP_PUSH = 5'h07,
		OP_POP = 5'h08,
		OP_CALL_SAVE = 5'h09,
		OP_INTERRUPT_RETURN = 5'h0A,
		OP_INDIRECT_INCREMENT = 5'h0B,
		OP_REGISTER_DECREMENT = 5'h0C,
		OP_BIT_CLEAR = 5'h0D,
		OP_BIT_SET = 5'h0E,
		OP_BIT_COMPLEMENT = 5'h0F,
		OP_BIT_TEST = 5'h10,
		OP_BIT_WRITE = 5'h11
	} dma_op_t;

	typedef struct packed {
		dma_op_t op;
		logic [2:0] reg_sel;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [15:0] pc;
	} dma_req_t;

	typedef struct packed {
		logic done;
		logic [7:0] rdata;
		logic bit_value;
		logic [15:0] pc;
	} dma_rsp_t;
endpackage : dma_pkg
